// File: core/scs_clock_ctrl.sv
// clock source select, ready/failure flags and peripheral resets over APB
//
// Notes on behaviour
// - two-bit source select; code 11 never stored
// - force internal fast on wake or failure
// - status field reports source actually in use
// - failure flag set on external fast failure
// - failure clear bit: one clears, zero nothing
// - PLL ready flags set on lock if enabled
// - external fast ready flag when stable, enabled
// - internal fast ready flag when stable, enabled
// - external slow ready flag when stable, enabled
// - internal slow ready flag when stable, enabled
// - seven read-write enables at bits 14:8
// - ready clear bits 22:16 clear flag below
// - flags read-only, clears write-only, reserved zero
// - bit 14 holds serial transceiver in reset
// - bits 12, 11 hold SPI and timer reset
// - bits 10, 9 hold converters in reset
// - bits 6:2 hold GPIO ports E..A reset
// - bit 0 holds alternate-function remap reset
// - reserved reset-register bits read zero
// - any width access, no wait states
// - supervision active only once external ready
`timescale 1ns/1ps
`include "scs_defines.svh"

module scs_clock_ctrl
(
    input wire logic clock,
    input wire logic reset,
    input wire scs_pkg::scs_apb_req_type apbReq,
    output scs_pkg::scs_apb_rsp_type apbRsp,
    input wire logic [`SCS_NUM_IN-1:0] oscMonitor,
    output scs_pkg::scs_src_type sysclkSourceStatus,
    output logic clockCtrlIrq,
    output scs_pkg::scs_periph_rst_type periphReset
);

    // byte-lane merge of a write into a register, limited to writable bits
    function automatic logic [31:0] mergeBytes
    (
        input logic [31:0] oldValue,
        input logic [31:0] wdata,
        input logic [3:0] strobe,
        input logic [31:0] mask
    );
        logic [31:0] laneMask;
        laneMask = {{8{strobe[3]}}, {8{strobe[2]}},
                    {8{strobe[1]}}, {8{strobe[0]}}} & mask;
        return (oldValue & ~laneMask) | (wdata & laneMask);
    endfunction : mergeBytes

    function automatic logic [31:0] rstToWord
    (
        input scs_pkg::scs_periph_rst_type r
    );
        logic [31:0] w;
        w = `SCS_RESET_WORD;
        w[`SCS_PRST_SER1] = r.serial1Reset;
        w[`SCS_PRST_SPI1] = r.spiPort1Reset;
        w[`SCS_PRST_TIM] = r.advTimerReset;
        w[`SCS_PRST_CONV2] = r.converter2Reset;
        w[`SCS_PRST_CONV1] = r.converter1Reset;
        w[`SCS_PRST_GPIOE] = r.gpioEReset;
        w[`SCS_PRST_GPIOD] = r.gpioDReset;
        w[`SCS_PRST_GPIOC] = r.gpioCReset;
        w[`SCS_PRST_GPIOB] = r.gpioBReset;
        w[`SCS_PRST_GPIOA] = r.gpioAReset;
        w[`SCS_PRST_AFIO] = r.altFuncIoReset;
        return w;
    endfunction : rstToWord

    function automatic scs_pkg::scs_periph_rst_type wordToRst
    (
        input logic [31:0] w
    );
        scs_pkg::scs_periph_rst_type r;
        r.serial1Reset = w[`SCS_PRST_SER1];
        r.spiPort1Reset = w[`SCS_PRST_SPI1];
        r.advTimerReset = w[`SCS_PRST_TIM];
        r.converter2Reset = w[`SCS_PRST_CONV2];
        r.converter1Reset = w[`SCS_PRST_CONV1];
        r.gpioEReset = w[`SCS_PRST_GPIOE];
        r.gpioDReset = w[`SCS_PRST_GPIOD];
        r.gpioCReset = w[`SCS_PRST_GPIOC];
        r.gpioBReset = w[`SCS_PRST_GPIOB];
        r.gpioAReset = w[`SCS_PRST_GPIOA];
        r.altFuncIoReset = w[`SCS_PRST_AFIO];
        return r;
    endfunction : wordToRst

    // monitor inputs come from the analogue side: three-stage synchroniser
    logic [`SCS_NUM_IN-1:0] syncFirst;
    logic [`SCS_NUM_IN-1:0] syncSecond;
    logic [`SCS_NUM_IN-1:0] syncThird;
    logic [`SCS_NUM_IN-1:0] monStable;
    logic [`SCS_NUM_IN-1:0] monRise;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            syncFirst <= '0;
            syncSecond <= '0;
            syncThird <= '0;
        end
        else
        begin
            syncFirst <= oscMonitor;
            syncSecond <= syncFirst;
            syncThird <= syncSecond;
        end
    end

    // a change counts only once the second and third stages agree
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            monStable <= '0;
        end
        else
        begin
            for (int i = 0; i < `SCS_NUM_IN; i++)
            begin
                if (syncSecond[i] == syncThird[i])
                begin
                    monStable[i] <= syncThird[i];
                end
            end
        end
    end

    assign monRise = syncSecond & syncThird & ~monStable;

    // bus decode
    logic setupPhase;
    logic writeTaken;
    logic addrHit;
    logic [31:0] busWdata;
    logic [3:0] busStrobe;
    logic wrCtrl;
    logic wrCfg;
    logic wrCir;
    logic wrPrst;

    assign setupPhase = apbReq.psel & ~apbReq.penable;
    // pready is high from the first cycle after reset, so no wait states
    assign writeTaken = apbReq.psel & apbReq.penable & apbRsp.pready
                        & apbReq.pwrite & addrHit;
    assign busWdata = apbReq.pwdata;
    assign busStrobe = apbReq.pstrb;
    assign wrCtrl = writeTaken & (apbReq.paddr == `SCS_OFF_CTRL);
    assign wrCfg = writeTaken & (apbReq.paddr == `SCS_OFF_CFG);
    assign wrCir = writeTaken & (apbReq.paddr == `SCS_OFF_CIR);
    assign wrPrst = writeTaken & (apbReq.paddr == `SCS_OFF_PRST);

    always_comb
    begin
        unique case (apbReq.paddr)
            `SCS_OFF_CTRL,
            `SCS_OFF_CFG,
            `SCS_OFF_CIR,
            `SCS_OFF_PRST: addrHit = 1'b1;
            default: addrHit = 1'b0;
        endcase
    end

    // control register: clock supervision enable
    logic [31:0] ctrlWord;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            ctrlWord <= `SCS_RESET_WORD;
        end
        else if (wrCtrl)
        begin
            ctrlWord <= mergeBytes(ctrlWord, busWdata, busStrobe,
                                   32'h1 << `SCS_CTRL_SUPV_BIT);
        end
    end

    logic clockSupervisionEnable;
    assign clockSupervisionEnable = ctrlWord[`SCS_CTRL_SUPV_BIT];

    // failure only counts with supervision on and external fast ready
    logic failDetect;
    assign failDetect = monRise[`SCS_IN_FAIL] & clockSupervisionEnable
                        & monStable[`SCS_IN_EXT_FAST];

    // source select and switch status
    scs_pkg::scs_src_type sysclkSourceSelect;
    scs_pkg::scs_src_type requestedSource;
    logic forceInternal;
    logic targetReady;

    assign requestedSource =
        scs_pkg::scs_src_type'(busWdata[`SCS_SEL_LO +: 2]);
    // fallback applies while the failing oscillator feeds the system
    assign forceInternal = monRise[`SCS_IN_WAKE]
        | (failDetect
           & (sysclkSourceStatus != scs_pkg::SRC_INT_FAST));

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            sysclkSourceSelect <= scs_pkg::SRC_INT_FAST;
        end
        else if (forceInternal)
        begin
            sysclkSourceSelect <= scs_pkg::SRC_INT_FAST;
        end
        else if (wrCfg & busStrobe[0]
                 & (requestedSource != scs_pkg::SRC_NONE))
        begin
            sysclkSourceSelect <= requestedSource;
        end
    end

    always_comb
    begin
        unique case (sysclkSourceSelect)
            scs_pkg::SRC_INT_FAST:
                targetReady = monStable[`SCS_IN_INT_FAST];
            scs_pkg::SRC_EXT_FAST:
                targetReady = monStable[`SCS_IN_EXT_FAST];
            scs_pkg::SRC_MAIN_PLL:
                targetReady = monStable[`SCS_IN_MAIN_PLL];
            default:
                targetReady = 1'b0;
        endcase
    end

    // a requested switch completes once the new source is ready;
    // a forced fallback is taken at once, since the old source is gone
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            sysclkSourceStatus <= scs_pkg::SRC_INT_FAST;
        end
        else if (forceInternal)
        begin
            sysclkSourceStatus <= scs_pkg::SRC_INT_FAST;
        end
        else if (targetReady)
        begin
            sysclkSourceStatus <= sysclkSourceSelect;
        end
    end

    // interrupt register: enables, ready flags, failure flag
    logic [`SCS_NUM_RDY-1:0] readyIrqEn;
    logic [`SCS_NUM_RDY-1:0] readyFlag;
    logic clockFailFlag;
    logic [`SCS_NUM_RDY-1:0] readyClear;
    logic clockFailClear;
    logic [`SCS_NUM_RDY-1:0] next_readyFlag;
    logic next_clockFailFlag;
    logic [31:0] cirEnMask;
    logic [31:0] cirMerged;

    assign cirEnMask = {{(32 - `SCS_NUM_RDY){1'b0}},
                        {`SCS_NUM_RDY{1'b1}}} << `SCS_CIR_EN_LO;
    assign cirMerged = mergeBytes(32'(readyIrqEn) << `SCS_CIR_EN_LO,
                                  busWdata, busStrobe, cirEnMask);

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            readyIrqEn <= '0;
        end
        else if (wrCir)
        begin
            readyIrqEn <= cirMerged[`SCS_CIR_EN_LO +: `SCS_NUM_RDY];
        end
    end

    // clear bits act only on a write with their lane enabled
    assign readyClear = (wrCir & busStrobe[2])
        ? busWdata[`SCS_CIR_CLR_LO +: `SCS_NUM_RDY]
        : '0;
    assign clockFailClear = wrCir & busStrobe[2]
        & busWdata[`SCS_CIR_FAIL_CLR_BIT];

    // set wins over a clear arriving in the same cycle
    assign next_readyFlag = (readyFlag & ~readyClear)
        | (monRise[`SCS_NUM_RDY-1:0] & readyIrqEn);
    assign next_clockFailFlag = (clockFailFlag & ~clockFailClear)
        | failDetect;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            readyFlag <= '0;
            clockFailFlag <= 1'b0;
        end
        else
        begin
            readyFlag <= next_readyFlag;
            clockFailFlag <= next_clockFailFlag;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            clockCtrlIrq <= 1'b0;
        end
        else
        begin
            clockCtrlIrq <= (|next_readyFlag)
                            | next_clockFailFlag;
        end
    end

    // peripheral reset register drives the hold-in-reset lines directly
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            periphReset <= wordToRst(`SCS_RESET_WORD);
        end
        else if (wrPrst)
        begin
            periphReset <= wordToRst(mergeBytes(
                rstToWord(periphReset), busWdata, busStrobe,
                rstToWord(wordToRst(32'hffffffff))));
        end
    end

    // read mux; reserved and write-only bits come back as zero
    logic [31:0] cfgWord;
    logic [31:0] cirWord;
    logic [31:0] readWord;

    always_comb
    begin
        cfgWord = `SCS_RESET_WORD;
        cfgWord[`SCS_SEL_LO +: 2] = sysclkSourceSelect;
        cfgWord[`SCS_STAT_LO +: 2] = sysclkSourceStatus;
    end

    always_comb
    begin
        cirWord = `SCS_RESET_WORD;
        cirWord[`SCS_NUM_RDY-1:0] = readyFlag;
        cirWord[`SCS_CIR_FAIL_BIT] = clockFailFlag;
        cirWord[`SCS_CIR_EN_LO +: `SCS_NUM_RDY] = readyIrqEn;
    end

    always_comb
    begin
        unique case (apbReq.paddr)
            `SCS_OFF_CTRL: readWord = ctrlWord;
            `SCS_OFF_CFG: readWord = cfgWord;
            `SCS_OFF_CIR: readWord = cirWord;
            `SCS_OFF_PRST: readWord = rstToWord(periphReset);
            default: readWord = `SCS_RESET_WORD;
        endcase
    end

    // read data is captured in the setup cycle so it is valid from a
    // flop in the access cycle; a flag set between the two shows next read
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            apbRsp.prdata <= `SCS_RESET_WORD;
            apbRsp.pslverr <= 1'b0;
            apbRsp.pready <= 1'b0;
        end
        else
        begin
            apbRsp.pready <= 1'b1;
            if (setupPhase)
            begin
                apbRsp.prdata <= apbReq.pwrite ? `SCS_RESET_WORD
                                               : readWord;
                apbRsp.pslverr <= ~addrHit;
            end
        end
    end

endmodule : scs_clock_ctrl

// File: core/scs_defines.svh
// register map, field positions and reset values of the clock controller
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH
`define SCS_ADDR_W 12
`define SCS_OFF_CTRL 12'h000
`define SCS_OFF_CFG 12'h004
`define SCS_OFF_CIR 12'h008
`define SCS_OFF_PRST 12'h00c
`define SCS_RESET_WORD 32'h00000000
`define SCS_CTRL_SUPV_BIT 19
`define SCS_SEL_LO 0
`define SCS_STAT_LO 2
`define SCS_NUM_RDY 7
`define SCS_CIR_FAIL_BIT 7
`define SCS_CIR_EN_LO 8
`define SCS_CIR_CLR_LO 16
`define SCS_CIR_FAIL_CLR_BIT 23
`define SCS_IN_INT_SLOW 0
`define SCS_IN_EXT_SLOW 1
`define SCS_IN_INT_FAST 2
`define SCS_IN_EXT_FAST 3
`define SCS_IN_MAIN_PLL 4
`define SCS_IN_FAIL 7
`define SCS_IN_WAKE 8
`define SCS_NUM_IN 9
`define SCS_PRST_SER1 14
`define SCS_PRST_SPI1 12
`define SCS_PRST_TIM 11
`define SCS_PRST_CONV2 10
`define SCS_PRST_CONV1 9
`define SCS_PRST_GPIOE 6
`define SCS_PRST_GPIOD 5
`define SCS_PRST_GPIOC 4
`define SCS_PRST_GPIOB 3
`define SCS_PRST_GPIOA 2
`define SCS_PRST_AFIO 0
`endif

// File: core/scs_pkg.sv
// types shared by the clock controller and its bench
`include "scs_defines.svh"
package scs_pkg;
    typedef enum logic [1:0]
    {
        SRC_INT_FAST = 2'h0,
        SRC_EXT_FAST = 2'h1,
        SRC_MAIN_PLL = 2'h2,
        SRC_NONE = 2'h3
    } scs_src_type;
    typedef struct packed
    {
        logic psel;
        logic penable;
        logic pwrite;
        logic [`SCS_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } scs_apb_req_type;
    typedef struct packed
    {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } scs_apb_rsp_type;
    typedef struct packed
    {
        logic serial1Reset;
        logic spiPort1Reset;
        logic advTimerReset;
        logic converter2Reset;
        logic converter1Reset;
        logic gpioEReset;
        logic gpioDReset;
        logic gpioCReset;
        logic gpioBReset;
        logic gpioAReset;
        logic altFuncIoReset;
    } scs_periph_rst_type;
endpackage : scs_pkg

// File: sim/scs_clock_ctrl_bench.sv
// self-checking bench for the clock controller
`timescale 1ns/1ps

module scs_clock_ctrl_bench;
    logic clock;
    logic reset;
    scs_pkg::scs_apb_req_type req;
    scs_pkg::scs_apb_rsp_type rsp;
    logic [8:0] mon;
    scs_pkg::scs_src_type status;
    logic irq;
    scs_pkg::scs_periph_rst_type prst;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [31:0] rdata;
    logic err;

    scs_clock_ctrl i_dut
    (
        .clock(clock),
        .reset(reset),
        .apbReq(req),
        .apbRsp(rsp),
        .oscMonitor(mon),
        .sysclkSourceStatus(status),
        .clockCtrlIrq(irq),
        .periphReset(prst)
    );

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic report_and_stop;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    // the whole run needs about 470 cycles
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            $display("BAD %s expected %h seen %h", n, e, g);
            n_errors++;
        end
    endtask : chk

    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s);
        @(posedge clock);
        req <= {1'b1, 1'b0, w, a, d, s};
        @(posedge clock);
        req.penable <= 1'b1;
        do
            @(posedge clock);
        while (rsp.pready !== 1'b1);
        rdata = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask : xfer

    // a few idle cycles let a source switch settle before the next read
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hf);
        repeat (3) @(posedge clock);
    endtask : wr

    task automatic rd(input string n, input logic [11:0] a,
        input logic [31:0] e);
        xfer(1'b0, a, 32'h0, 4'hf);
        chk(n, e, rdata);
    endtask : rd

    // levels are held well past the three synchroniser stages
    task automatic pulse(input int i);
        mon[i] <= 1'b1;
        repeat (8) @(posedge clock);
        mon[i] <= 1'b0;
        repeat (8) @(posedge clock);
    endtask : pulse

    initial
    begin
        reset = 1'b1;
        req = '0;
        mon = 9'h0;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        rd("cir", 12'h008, 32'h0);
        rd("prst", 12'h00c, 32'h0);
        wr(12'h00c, 32'hffffffff);
        rd("prst", 12'h00c, 32'h00005e7d);
        chk("prstPort", 32'h7ff, 32'(prst));
        xfer(1'b1, 12'h00c, 32'h0, 4'h1);
        rd("prstByte", 12'h00c, 32'h00005e00);
        chk("prstPort", 32'h7c0, 32'(prst));
        wr(12'h00c, 32'h0);
        chk("prstPort", 32'h0, 32'(prst));
        wr(12'h008, 32'hffffffff);
        rd("cirEn", 12'h008, 32'h00007f00);
        chk("irq", 32'h0, 32'(irq));
        for (int i = 0; i < 7; i++)
        begin
            pulse(i);
            wr(12'h008, 32'h00007fff);
            rd("flag", 12'h008, 32'h00007f00 | (32'h1 << i));
            chk("irq", 32'h1, 32'(irq));
            wr(12'h008, 32'h00007f00 | (32'h1 << (i + 16)));
            rd("clr", 12'h008, 32'h00007f00);
            chk("irq", 32'h0, 32'(irq));
        end
        // one flag up, then every clear bit at once must drop the interrupt
        pulse(0);
        rd("flag0", 12'h008, 32'h00007f01);
        wr(12'h008, 32'h00ff7f00);
        rd("clrAll", 12'h008, 32'h00007f00);
        chk("irqAll", 32'h0, 32'(irq));
        wr(12'h008, 32'h0);
        mon[3] <= 1'b1;
        mon[4] <= 1'b1;
        repeat (8) @(posedge clock);
        rd("noEn", 12'h008, 32'h0);
        wr(12'h004, 32'h1);
        rd("ext", 12'h004, 32'h5);
        wr(12'h004, 32'h3);
        rd("bad", 12'h004, 32'h5);
        chk("stat", 32'h1, 32'(status));
        wr(12'h004, 32'h2);
        rd("pll", 12'h004, 32'ha);
        wr(12'h004, 32'h1);
        wr(12'h000, 32'h00080000);
        pulse(7);
        rd("fail", 12'h008, 32'h80);
        rd("fallback", 12'h004, 32'h0);
        chk("irq", 32'h1, 32'(irq));
        wr(12'h008, 32'h0);
        rd("failKeep", 12'h008, 32'h80);
        wr(12'h008, 32'h00800000);
        rd("failClr", 12'h008, 32'h0);
        wr(12'h000, 32'h0);
        wr(12'h004, 32'h1);
        pulse(7);
        rd("noSup", 12'h008, 32'h0);
        rd("noFall", 12'h004, 32'h5);
        pulse(8);
        rd("wake", 12'h004, 32'h0);
        xfer(1'b0, 12'h010, 32'h0, 4'hf);
        chk("slverr", 32'h1, 32'(err));
        report_and_stop();
    end
endmodule : scs_clock_ctrl_bench

// File: sim/scs_clock_ctrl_chk.sv
// port-level assertion checker for the clock controller
`timescale 1ns/1ps
`include "scs_defines.svh"

module scs_clock_ctrl_chk
(
    input wire logic clock,
    input wire logic reset,
    input wire scs_pkg::scs_apb_req_type apbReq,
    input wire scs_pkg::scs_apb_rsp_type apbRsp,
    input wire logic [`SCS_NUM_IN-1:0] oscMonitor,
    input wire scs_pkg::scs_src_type sysclkSourceStatus,
    input wire logic clockCtrlIrq,
    input wire scs_pkg::scs_periph_rst_type periphReset
);
    logic acc;
    logic wrC;
    logic rdA;
    logic [31:0] prstWord;
    logic [`SCS_NUM_IN-1:0] prevMon;
    logic [3:0] quiet;
    logic [6:0] enShadow;

    assign acc = apbReq.psel && apbReq.penable && apbRsp.pready;
    assign wrC = acc && apbReq.pwrite && apbReq.paddr == 12'h00c;
    assign rdA = apbReq.psel && apbReq.penable && !apbReq.pwrite;
    assign prstWord = {17'h0, periphReset.serial1Reset, 1'b0,
        periphReset.spiPort1Reset, periphReset.advTimerReset,
        periphReset.converter2Reset, periphReset.converter1Reset, 2'h0,
        periphReset.gpioEReset, periphReset.gpioDReset,
        periphReset.gpioCReset, periphReset.gpioBReset,
        periphReset.gpioAReset, 1'b0, periphReset.altFuncIoReset};

    // cycles since the monitor inputs last moved; an event is still in
    // the synchronisers while this is small
    always_ff @(posedge clock)
    begin
        prevMon <= oscMonitor;
        if (reset || oscMonitor != prevMon)
            quiet <= 4'h0;
        else if (quiet != 4'hf)
            quiet <= quiet + 4'h1;
    end

    // shadow of the enable byte, so events can be judged without a read
    always_ff @(posedge clock)
    begin
        if (reset)
            enShadow <= 7'h0;
        else if (acc && apbReq.pwrite && apbReq.paddr == 12'h008
            && apbReq.pstrb[1])
            enShadow <= apbReq.pwdata[14:8];
    end

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    a_pready_no_wait: assert property (
        !$past(reset) |-> apbRsp.pready)
        else $error("pready low after reset");
    a_status_legal: assert property (
        sysclkSourceStatus != scs_pkg::SRC_NONE)
        else $error("status shows code 11");
    a_prst_write: assert property (
        wrC && apbReq.pstrb == 4'hf
        |=> prstWord == ($past(apbReq.pwdata) & 32'h00005e7d))
        else $error("peripheral reset outputs differ from written word");
    a_prst_hold: assert property (
        !wrC |=> $stable(prstWord))
        else $error("peripheral reset changed without a write");
    a_prst_read: assert property (
        rdA && apbReq.paddr == 12'h00c |-> apbRsp.prdata == prstWord)
        else $error("reset register read differs from outputs");
    a_cir_upper_read: assert property (
        rdA && apbReq.paddr == 12'h008
        |-> apbRsp.prdata[31:8] == {17'h0, enShadow})
        else $error("interrupt register upper bits read wrong");
    a_irq_on_event: assert property (
        (|(oscMonitor[6:0] & ~$past(oscMonitor[6:0]) & enShadow))
        |-> ##[3:6] clockCtrlIrq)
        else $error("enabled ready event raised no interrupt");
    a_irq_has_cause: assert property (
        $rose(clockCtrlIrq) |-> quiet < 4'h8)
        else $error("interrupt rose with no monitor event");
    a_irq_clear_all: assert property (
        acc && apbReq.pwrite && apbReq.paddr == 12'h008 && apbReq.pstrb[2]
        && apbReq.pwdata[23:16] == 8'hff && quiet > 4'h9
        |=> !clockCtrlIrq)
        else $error("interrupt stayed high after clearing all");
    a_wake_fallback: assert property (
        $rose(oscMonitor[8])
        |-> ##[3:6] sysclkSourceStatus == scs_pkg::SRC_INT_FAST)
        else $error("no fallback to internal fast after wake");
endmodule : scs_clock_ctrl_chk

bind scs_clock_ctrl scs_clock_ctrl_chk i_chk
(
    .clock(clock),
    .reset(reset),
    .apbReq(apbReq),
    .apbRsp(apbRsp),
    .oscMonitor(oscMonitor),
    .sysclkSourceStatus(sysclkSourceStatus),
    .clockCtrlIrq(clockCtrlIrq),
    .periphReset(periphReset)
);
